// ==== design/call_signalling.sv ====
// Function
// - class 1 characters use column 3, b7..b5 fixed at 0,1,1.
// - b8 gives even parity on class 1 characters; received parity checked.
// - forward digits 0..9 coded binary in b4..b1.
// - forward ZAZA ends selection for class 2, else through-connected.
// - forward ZAZZ ends calling line identity, may follow network code.
// - class 1 selection ends with character 2/11.
// - forward 0/6 is originating through-connection, 2/15 starts extension.
// - a bad first character releases the call, backward kept at start.
// - later errors answer confirm, ident, progress 20, then clearing.
// - selection unfinished 15 s after first character gives 20 and clear.
// - international number holds at most 14 digits.
// - extended address accepted up to 32 digits, not interpreted.
// - congestion at transit answers confirm, ident, progress 61, clear.
// - four ident digits always follow reception-confirmation.
// - transit waits 2 s for first network ident, else 20 and clear.
// - backward characters from later centres buffered and relayed intact.
// - backward digits 0..9 coded binary in b4..b1.
// - backward ZAZA introduces a two-digit call progress signal.
// - backward ZAZZ starts network identification, four ident digits follow.
// - backward ZZZA starts a transit through-connect signal.
// - backward ZZZZ announces a further backward character.
// - backward 2/10 is reception-confirmation.
module call_signalling
   import call_sig_pkg::*;
#(
   parameter int PRESCALE  = PRESCALE_DEF,
   parameter int SEL_TICKS = SEL_TICKS_DEF,
   parameter int NET_TICKS = NET_TICKS_DEF,
   parameter int DEPTH     = 8
) (
   input  wire logic        clk,           // system clock
   input  wire logic        sys_rst,       // sync reset, high
   input  wire logic [31:0] paddr,         // apb address
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb enable
   input  wire logic        pwrite,        // apb write
   input  wire logic [31:0] pwdata,        // apb write data
   output logic      [31:0] prdata,        // apb read data
   output logic             pready,        // apb ready
   output logic             pslverr,       // apb error
   input  wire logic        fwd_rx_valid,  // forward char strobe
   input  wire logic [7:0]  fwd_rx_char,   // forward char
   input  wire logic        congestion,    // reception-congestion seen
   input  wire logic        sub_rx_valid,  // backward char from later
   input  wire logic [7:0]  sub_rx_char,   // backward char from later
   output logic             sub_rx_ready,  // relay buffer has room
   output logic             bwd_tx_valid,  // backward char offered
   output logic      [7:0]  bwd_tx_char,   // backward char
   input  wire logic        bwd_tx_ready,  // backward char taken
   output logic             call_release,  // release pulse
   output logic             call_clear     // clearing pulse
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      state_e                 st;
      logic [7:0]             cause;
      logic [4:0]             dcnt;
      logic [5:0]             xcnt;
      logic [1:0]             idx;
      logic [31:0]            presc;
      logic [15:0]            tmr;
      logic [DEPTH-1:0][7:0]  mem;
      logic [PW-1:0]          wp;
      logic [PW-1:0]          rp;
      logic [CW-1:0]          cnt;
      logic [2:0]             ctrl;
      logic [15:0]            ident;
      logic                   perr;
      logic                   thru;
      logic                   transit_through_connected;
      logic                   cli;
      logic                   transit_connect_start;
      logic                   bext;
      logic                   bcp;
      logic                   tx_valid;
      logic [7:0]             tx_char;
      logic                   rel;
      logic                   clr;
      logic                   pready;
      logic                   pslverr;
      logic [31:0]            prdata;
      logic                   sub_ready;
   } state_s;

   state_s q, d;

   function automatic logic [7:0] enc(input logic [6:0] c);
      return {^c, c};
   endfunction : enc

   logic       class2, push, pop, tick, sel_to, net_to;
   logic [3:0] code;
   logic       good, digit, apb_acc;
   logic [6:0] och;
   logic [3:0] onib;

   always_comb begin
      d       = q;
      class2  = q.ctrl[CTRL_CLASS2];
      code    = fwd_rx_char[3:0];
      good    = class2 || (^fwd_rx_char == 1'b0);
      digit   = (class2 ? fwd_rx_char[7:4] == 4'h0
                 : fwd_rx_char[6:4] == COL3) && code <= DIGIT_MAX;
      push    = 1'b0;
      pop     = 1'b0;
      och     = 7'h00;
      onib    = 4'h0;
      d.rel   = 1'b0;
      d.clr   = 1'b0;
      // prescaled tick and supervision count
      tick    = q.presc == 32'(PRESCALE - 1);
      d.presc = tick ? 32'h0 : q.presc + 32'h1;
      if (tick) begin
         d.tmr = q.tmr + 16'h1;
      end
      sel_to  = q.tmr >= 16'(SEL_TICKS) && q.ctrl[CTRL_TOEN];
      net_to  = q.tmr >= 16'(NET_TICKS);

      // relay buffer fill, never overwrites
      if (sub_rx_valid && q.sub_ready) begin
         push                       = 1'b1;
         d.mem[q.wp]                = sub_rx_char;
         d.wp                       = q.wp + PW'(1);
         if (sub_rx_char[3:0] == CODE_ZZZA) begin
            d.transit_connect_start = 1'b1;
         end
         if (sub_rx_char[3:0] == CODE_ZZZZ) begin
            d.bext = 1'b1;
         end
         if (sub_rx_char[3:0] == CODE_ZAZA) begin
            d.bcp = 1'b1;
         end
      end

      // handshake completion on the backward path
      if (q.tx_valid && bwd_tx_ready) begin
         d.tx_valid = 1'b0;
      end

      case (q.st)
         S_IDLE: begin
            if (fwd_rx_valid) begin
               d.tmr   = 16'h0;
               d.dcnt  = 5'h0;
               d.xcnt  = 6'h0;
               d.cause = CP_NONE;
               {d.perr, d.thru, d.transit_through_connected, d.cli} = 4'h0;
               d.transit_connect_start = push && sub_rx_char[3:0] == CODE_ZZZA;
               d.bext = push && sub_rx_char[3:0] == CODE_ZZZZ;
               d.bcp  = push && sub_rx_char[3:0] == CODE_ZAZA;
               if (good && (class2 || fwd_rx_char[6:4] == COL3)) begin
                  d.st = S_SEL;
               end else begin
                  d.rel = 1'b1;
               end
            end
         end
         S_SEL, S_EXT: begin
            if (congestion && q.ctrl[CTRL_TRANSIT]) begin
               d.cause = CP_CONG;
               d.st    = S_CONF;
            end else if (fwd_rx_valid) begin
               if (!good) begin
                  d.perr  = 1'b1;
                  d.cause = CP_FAIL;
                  d.st    = S_CONF;
               end else if (q.st == S_EXT && digit
                            && q.xcnt < MAX_EXT_DIGITS) begin
                  d.xcnt = q.xcnt + 6'h1;
               end else if (q.st == S_SEL && digit
                            && q.dcnt < MAX_NUM_DIGITS) begin
                  d.dcnt = q.dcnt + 5'h1;
               end else if (class2 && fwd_rx_char == {4'h0, CODE_ZAZA}) begin
                  d.st = S_CONF;
               end else if (!class2 && fwd_rx_char[6:0] == CH_EOS1) begin
                  d.st = S_CONF;
               end else if (q.st == S_SEL && !class2
                            && fwd_rx_char[6:0] == {COL3, CODE_ZAZA}) begin
                  d.transit_through_connected = 1'b1;
               end else if (q.st == S_SEL && code == CODE_ZAZZ
                            && fwd_rx_char[6:4] == (class2 ? 3'h0 : COL3)
                            && q.dcnt >= 5'd4) begin
                  d.cli = 1'b1;
               end else if (q.st == S_SEL && !class2
                            && fwd_rx_char[6:0] == CH_ORIG) begin
                  d.thru = 1'b1;
               end else if (q.st == S_SEL && !class2
                            && fwd_rx_char[6:0] == CH_EXTADDR) begin
                  d.st = S_EXT;
               end else begin
                  d.cause = CP_FAIL;
                  d.st    = S_CONF;
               end
            end else if (sel_to) begin
               d.cause = CP_FAIL;
               d.st    = S_CONF;
            end
         end
         S_WNET, S_THRU: begin
            if (q.st == S_WNET && congestion && !q.tx_valid) begin
               d.cause = CP_CONG;
               d.st    = S_CPS;
            end else if (q.st == S_WNET && push
                         && (sub_rx_char[3:0] <= DIGIT_MAX
                             || sub_rx_char[3:0] == CODE_ZAZZ)) begin
               d.st = S_THRU;
            end else if (q.st == S_WNET && net_to && !q.tx_valid) begin
               d.cause = CP_FAIL;
               d.st    = S_CPS;
            end
            if (!q.tx_valid && q.cnt != CW'(0) && d.st != S_CPS) begin
               pop        = 1'b1;
               d.tx_valid = 1'b1;
               d.tx_char  = q.mem[q.rp];
               d.rp       = q.rp + PW'(1);
            end
         end
         S_CLR: begin
            d.clr = 1'b1;
            d.st  = S_IDLE;
         end
         default: begin
            d.st = S_IDLE;
         end
      endcase

      // own backward characters, one state per character except S_ID, which sends all four ident digits
      case (q.st)
         S_CONF: och = CH_CONFIRM;
         S_NIS:  onib = CODE_ZAZZ;
         S_ID:   onib = q.ident[4'(12 - 4 * q.idx) +: 4];
         S_CPS:  onib = CODE_ZAZA;
         S_CP1:  onib = q.cause[7:4];
         S_CP2:  onib = q.cause[3:0];
         default: onib = 4'h0;
      endcase
      if (q.st >= S_CONF && q.st <= S_CP2) begin
         d.st = q.st;
         if (!q.tx_valid) begin
            d.tx_valid = 1'b1;
            d.tx_char  = q.st == S_CONF ? enc(och)
                       : class2 ? {4'h0, onib}
                       : enc({COL3, onib});
         end else if (bwd_tx_ready) begin
            case (q.st)
               S_CONF: d.st = S_NIS;
               S_NIS:  d.st = S_ID;
               S_ID: begin
                  d.idx = q.idx + 2'h1;
                  if (q.idx == IDENT_LAST) begin
                     d.tmr = 16'h0;
                     d.st  = q.cause != CP_NONE ? S_CPS
                           : q.ctrl[CTRL_TRANSIT] ? S_WNET : S_THRU;
                  end
               end
               S_CPS:  d.st = S_CP1;
               S_CP1:  d.st = S_CP2;
               default: d.st = S_CLR;
            endcase
         end
      end

      if (push && !pop) begin
         d.cnt = q.cnt + CW'(1);
      end else if (pop && !push) begin
         d.cnt = q.cnt - CW'(1);
      end
      d.sub_ready = d.cnt < CW'(DEPTH);

      // apb slave, no wait states
      apb_acc   = psel && penable && q.pready;
      d.pready  = psel && !penable && !q.pready;
      d.pslverr = 1'b0;
      if (psel && !penable && !q.pready) begin
         d.prdata = 32'h0;
         case (paddr[7:0])
            ADDR_CTRL:   d.prdata = {29'h0, q.ctrl};
            ADDR_IDENT:  d.prdata = {16'h0, q.ident};
            ADDR_STATUS: begin
               d.prdata[ST_STATE +: 4] = q.st;
               d.prdata[ST_DCNT +: 5]  = q.dcnt;
               d.prdata[ST_XCNT +: 6]  = q.xcnt;
               d.prdata[ST_PERR]       = q.perr;
               d.prdata[ST_THRU]       = q.thru;
               d.prdata[ST_TTD]        = q.transit_through_connected;
               d.prdata[ST_CLI]        = q.cli;
               d.prdata[ST_TRANSIT_CONNECT_START]       = q.transit_connect_start;
               d.prdata[ST_BEXT]       = q.bext;
               d.prdata[ST_BCP]        = q.bcp;
            end
            default: d.pslverr = 1'b1;
         endcase
         if (paddr[31:8] != 24'h0) begin
            d.pslverr = 1'b1;
         end
      end
      if (apb_acc && pwrite && !q.pslverr) begin
         if (paddr[7:0] == ADDR_CTRL) begin
            d.ctrl = pwdata[2:0];
         end
         if (paddr[7:0] == ADDR_IDENT) begin
            d.ident = pwdata[15:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q       <= '0;
         q.st    <= S_IDLE;
         q.ctrl  <= CTRL_RST;
         q.ident <= IDENT_RST;
      end else begin
         q <= d;
      end
   end

   assign prdata       = q.prdata;
   assign pready       = q.pready;
   assign pslverr      = q.pslverr;
   assign sub_rx_ready = q.sub_ready;
   assign bwd_tx_valid = q.tx_valid;
   assign bwd_tx_char  = q.tx_char;
   assign call_release = q.rel;
   assign call_clear   = q.clr;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic own;
   assign own = q.st >= S_NIS && q.st <= S_CP2;

   property p_parity;
      q.tx_valid && !class2 && (own || q.st == S_CONF) |-> ^q.tx_char == 1'b0;
   endproperty
   a_parity: assert property (p_parity)
      else $error("odd parity on own backward char");
   property p_col3;
      q.tx_valid && !class2 && own |-> q.tx_char[6:4] == COL3;
   endproperty
   a_col3: assert property (p_col3)
      else $error("own backward char not in column 3");
   property p_conf;
      q.st == S_CONF && q.tx_valid |-> q.tx_char[6:0] == CH_CONFIRM;
   endproperty
   a_conf: assert property (p_conf)
      else $error("confirmation char wrong");

   property p_ident_next;
      q.st == S_CONF && q.tx_valid && bwd_tx_ready
         |=> q.st == S_NIS ##1 q.tx_valid && q.tx_char[3:0] == CODE_ZAZZ;
   endproperty
   a_ident_next: assert property (p_ident_next)
      else $error("identity does not follow confirmation");

   property p_bad_first;
      q.st == S_IDLE && fwd_rx_valid && !good |=> q.rel && q.st == S_IDLE;
   endproperty
   a_bad_first: assert property (p_bad_first)
      else $error("bad first char not released");

   property p_cp_clear;
      q.st == S_CP2 && q.tx_valid && bwd_tx_ready |=> q.st == S_CLR ##1 q.clr;
   endproperty
   a_cp_clear: assert property (p_cp_clear)
      else $error("clearing does not follow progress code");

   property p_parity_err;
      (q.st == S_SEL || q.st == S_EXT) && fwd_rx_valid && !good
         && !(congestion && q.ctrl[CTRL_TRANSIT])
         |=> q.st == S_CONF && q.cause == CP_FAIL;
   endproperty
   a_parity_err: assert property (p_parity_err)
      else $error("parity error not answered with 20");
   property p_cong;
      q.st == S_WNET && congestion && !q.tx_valid
         |=> q.cause == CP_CONG && q.st == S_CPS;
   endproperty
   a_cong: assert property (p_cong)
      else $error("congestion not answered with 61");

   property p_counts;
      q.dcnt <= MAX_NUM_DIGITS && q.xcnt <= MAX_EXT_DIGITS;
   endproperty
   a_counts: assert property (p_counts)
      else $error("digit count beyond limit");
   property p_relay;
      (q.st == S_THRU || q.st == S_WNET) && !q.tx_valid && q.cnt != CW'(0)
         && d.st != S_CPS
         |=> q.tx_valid && q.tx_char == $past(q.mem[q.rp]);
   endproperty
   a_relay: assert property (p_relay)
      else $error("relayed char altered");

   c_thru:  cover property (q.st == S_WNET ##1 q.st == S_THRU);
   c_cong:  cover property (q.st == S_CPS && q.cause == CP_CONG);
   c_rel:   cover property (q.rel);
   c_clear: cover property (q.clr && q.cause == CP_FAIL);
endmodule : call_signalling

// ==== design/call_sig_pkg.sv ====
package call_sig_pkg;
   // timing
   localparam int CLK_NS        = 10;
   localparam int TICK_NS       = 1_000_000;
   localparam int PRESCALE_DEF  = TICK_NS / CLK_NS;
   localparam int SEL_TIMEOUT_S = 15;
   localparam int NET_TIMEOUT_S = 2;
   localparam int TICKS_PER_S   = 1_000_000_000 / TICK_NS;
   localparam int SEL_TICKS_DEF = SEL_TIMEOUT_S * TICKS_PER_S;
   localparam int NET_TICKS_DEF = NET_TIMEOUT_S * TICKS_PER_S;
   // register map
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_IDENT  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam int CTRL_CLASS2  = 0;
   localparam int CTRL_TRANSIT = 1;
   localparam int CTRL_TOEN    = 2;
   localparam logic [2:0]  CTRL_RST  = 3'h4;
   localparam logic [15:0] IDENT_RST = 16'h0000;
   // status fields
   localparam int ST_STATE = 0;
   localparam int ST_DCNT  = 4;
   localparam int ST_XCNT  = 9;
   localparam int ST_PERR  = 16;
   localparam int ST_THRU  = 17;
   localparam int ST_TTD   = 18;
   localparam int ST_CLI   = 19;
   localparam int ST_TRANSIT_CONNECT_START  = 20;
   localparam int ST_BEXT  = 21;
   localparam int ST_BCP   = 22;
   // character coding, b1 in bit 0, A=0, Z=1
   localparam logic [2:0] COL3      = 3'h3;
   localparam logic [3:0] CODE_ZAZA = 4'hA;
   localparam logic [3:0] CODE_ZAZZ = 4'hB;
   localparam logic [3:0] CODE_ZZZA = 4'hE;
   localparam logic [3:0] CODE_ZZZZ = 4'hF;
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [6:0] CH_CONFIRM = 7'h2A;
   localparam logic [6:0] CH_EOS1    = 7'h2B;
   localparam logic [6:0] CH_EXTADDR = 7'h2F;
   localparam logic [6:0] CH_ORIG    = 7'h06;
   localparam logic [4:0] MAX_NUM_DIGITS = 5'd14;
   localparam logic [5:0] MAX_EXT_DIGITS = 6'd32;
   localparam logic [1:0] IDENT_LAST     = 2'd3;
   localparam logic [7:0] CP_NONE = 8'h00;
   localparam logic [7:0] CP_FAIL = 8'h20;
   localparam logic [7:0] CP_CONG = 8'h61;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_SEL  = 4'h1,
      S_EXT  = 4'h2,
      S_CONF = 4'h3,
      S_NIS  = 4'h4,
      S_ID   = 4'h5,
      S_CPS  = 4'h6,
      S_CP1  = 4'h7,
      S_CP2  = 4'h8,
      S_CLR  = 4'h9,
      S_WNET = 4'hA,
      S_THRU = 4'hB
   } state_e;
endpackage : call_sig_pkg

// ==== tb/far_centre.sv ====
module far_centre (
   input  wire logic       clk,          // clock
   input  wire logic       slow,         // stall the sink
   input  wire logic       bwd_tx_valid, // char offered
   input  wire logic [7:0] bwd_tx_char,  // char offered
   output logic            bwd_tx_ready, // sink accepts
   input  wire logic       sub_rx_ready, // relay has room
   output logic            sub_rx_valid, // later centre char
   output logic      [7:0] sub_rx_char   // later centre char
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   logic [1:0] cnt;
   initial begin
      cnt = 2'h0;
      bwd_tx_ready = 1'b0;
      sub_rx_valid = 1'b0;
      sub_rx_char = 8'h00;
   end
   // preceding centre: a char counts only on a valid and ready edge
   always @(posedge clk) begin
      if (bwd_tx_valid === 1'b1 && bwd_tx_ready) got.push_back(bwd_tx_char);
      cnt <= cnt + 2'h1;
      bwd_tx_ready <= !slow || cnt == 2'h3;
   end
   // later centre: coded char held until the relay takes it or 200 cycles pass
   task automatic send(input logic [7:0] c);
      int i;
      @(posedge clk);
      sub_rx_valid <= 1'b1;
      sub_rx_char <= c;
      for (i = 0; i < 200; i++) begin
         @(posedge clk);
         if (sub_rx_ready === 1'b1) break;
      end
      sub_rx_valid <= 1'b0;
      sub_rx_char <= ~c;
   endtask : send
endmodule : far_centre

// ==== tb/testbench.sv ====
module testbench
   import call_sig_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, se;
   logic [31:0] paddr, pwdata, prdata, rd, seed, ident;
   logic        fwd_rx_valid, congestion, sub_rx_valid, sub_rx_ready, slow;
   logic [7:0]  fwd_rx_char, sub_rx_char, bwd_tx_char;
   logic        bwd_tx_valid, bwd_tx_ready, call_release, call_clear;
   logic [7:0]  exq[$], rly[$];
   int          err_total, tests_run, clr_n, rel_n, i, c0;

   call_signalling #(.PRESCALE(4), .SEL_TICKS(60), .NET_TICKS(10))
   call_signalling_inst (
      .clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .fwd_rx_valid, .fwd_rx_char, .congestion,
      .sub_rx_valid, .sub_rx_char, .sub_rx_ready, .bwd_tx_valid,
      .bwd_tx_char, .bwd_tx_ready, .call_release, .call_clear
   );
   far_centre far_centre_inst (
      .clk, .slow, .bwd_tx_valid, .bwd_tx_char, .bwd_tx_ready,
      .sub_rx_ready, .sub_rx_valid, .sub_rx_char
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (call_clear === 1'b1) clr_n++;
      if (call_release === 1'b1) rel_n++;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic [7:0] enc(input logic [3:0] d, input logic c2);
      return c2 ? {4'h0, d} : {^{3'h3, d}, 3'h3, d};
   endfunction : enc

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results

   task automatic hung(input int n);
      if (n >= 3000) begin
         err_total++;
         results();
      end
   endtask : hung

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 3000 && pready !== 1'b1; k++) @(posedge clk);
      hung(k);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rst(input int n);
      sys_rst <= 1'b1;
      repeat (n) @(posedge clk);
      sys_rst <= 1'b0;
      far_centre_inst.got.delete();
      repeat (2) @(posedge clk);
   endtask : rst

   task automatic setup(input logic [2:0] ctrl);
      rst(2);
      apb(1'b1, ADDR_CTRL, {29'h0, ctrl});
      apb(1'b1, ADDR_IDENT, ident);
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, ident);
      slow <= ^rnd();
   endtask : setup

   task automatic fwd(input logic [7:0] c);
      @(posedge clk);
      fwd_rx_valid <= 1'b1;
      fwd_rx_char <= c;
      @(posedge clk);
      fwd_rx_valid <= 1'b0;
      fwd_rx_char <= ~c;
   endtask : fwd

   // own backward stream: confirm, ident start, ident, optional progress
   task automatic reply(input logic c2, logic [7:0] cp);
      int k;
      exq.push_back(8'hAA);
      exq.push_back(enc(CODE_ZAZZ, c2));
      for (k = 3; k >= 0; k--) exq.push_back(enc(ident[k*4+:4], c2));
      if (cp != CP_NONE) begin
         exq.push_back(enc(CODE_ZAZA, c2));
         exq.push_back(enc(cp[7:4], c2));
         exq.push_back(enc(cp[3:0], c2));
      end
   endtask : reply

   task automatic drain();
      int k;
      for (k = 0; k < 3000 && far_centre_inst.got.size() < exq.size(); k++)
         @(posedge clk);
      hung(k);
      while (exq.size() > 0)
         chk(far_centre_inst.got.pop_front(), exq.pop_front());
   endtask : drain

   // kind: 0 end, 1 parity, 2 congestion, 3 stall, 4 codes, 5 late congestion
   task automatic call(input logic c2, int nd, int nx, int kind,
                       logic [7:0] cp);
      int k, c1;
      c1 = clr_n;
      fwd(enc(4'h1, c2));
      for (k = 0; k < nd; k++) fwd(enc(4'(rnd() % 10), c2));
      if (nx > 0) fwd(8'hAF);
      for (k = 0; k < nx; k++) fwd(enc(4'(rnd() % 10), c2));
      if (kind == 1) fwd(enc(4'h5, c2) ^ 8'h80);
      if (kind == 2) congestion <= 1'b1;
      if (kind == 4) begin
         fwd(enc(CODE_ZAZZ, 1'b0));
         fwd(8'h06);
         fwd(enc(CODE_ZAZA, 1'b0));
      end
      if (kind == 0 || kind > 3) begin
         fwd(c2 ? {4'h0, CODE_ZAZA} : 8'h2B);
      end
      if (kind == 5) congestion <= 1'b1;
      reply(c2, cp);
      drain();
      for (k = 0; k < 3000 && cp != CP_NONE && clr_n == c1; k++)
         @(posedge clk);
      hung(k);
      chk(clr_n - c1, {31'h0, cp != CP_NONE});
      congestion <= 1'b0;
   endtask : call

   initial begin
      seed = 32'h7F550014;
      {sys_rst, psel, penable, pwrite, fwd_rx_valid, congestion} = 6'h20;
      slow = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      fwd_rx_char = 8'h00;
      rst(10);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, {29'h0, CTRL_RST});
      apb(1'b0, ADDR_IDENT, 32'h0);
      chk(rd, {16'h0, IDENT_RST});
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk({28'h0, rd[3:0]}, {28'h0, S_IDLE});
      apb(1'b0, 8'h0C, 32'h0);
      chk({31'h0, se}, 32'h1);
      ident = 32'h0;
      for (i = 0; i < 4; i++) ident[i*4+:4] = 4'(rnd() % 10);
      // spurious first char with odd parity
      c0 = rel_n;
      fwd(8'h31);
      for (i = 0; i < 3000 && rel_n == c0; i++) @(posedge clk);
      hung(i);
      chk(rel_n - c0, 1);
      chk(far_centre_inst.got.size(), 0);
      setup(3'h4);
      for (i = 0; i < 3; i++) rly.push_back(enc(4'(rnd() % 10), 1'b0));
      rly.push_back(enc(CODE_ZZZA, 1'b0));
      rly.push_back(enc(CODE_ZZZZ, 1'b0));
      rly.push_back(enc(CODE_ZAZA, 1'b0));
      fork
         call(1'b0, 14, 0, 4, CP_NONE);
         for (int j = 0; j < 6; j++) far_centre_inst.send(rly[j]);
      join
      exq = rly;
      drain();
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk((rd >> ST_PERR) & 32'hF, 32'hE);
      chk((rd >> ST_TRANSIT_CONNECT_START) & 32'h7, 32'h7);
      chk((rd >> ST_DCNT) & 32'h1F, 32'd14);
      setup(3'h4);
      call(1'b0, 15, 0, 0, CP_FAIL);
      setup(3'h4);
      call(1'b0, 6, 32, 0, CP_NONE);
      setup(3'h4);
      call(1'b0, 8, 0, 1, CP_FAIL);
      setup(3'h5);
      call(1'b1, 10, 0, 0, CP_NONE);
      setup(3'h4);
      call(1'b0, 3, 0, 3, CP_FAIL);
      setup(3'h6);
      call(1'b0, 5, 0, 2, CP_CONG);
      setup(3'h6);
      call(1'b0, 14, 0, 0, CP_FAIL);
      setup(3'h6);
      call(1'b0, 9, 0, 5, CP_CONG);
      chk(rel_n - c0, 1);
      results();
   end
endmodule : testbench
